/* hdl/gtc_pkg.sv */
// package of constants for the gated timer with asynchronous counting
package gtc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int COUNT_W   = 16;
  localparam int BYTE_W    = 8;
  localparam int PRESC_W   = 3;

  // ----------------------------------------------------------------
  // gate source select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] GATE_SRC_PIN  = 2'h0;
  localparam logic [1:0] GATE_SRC_T0   = 2'h1;
  localparam logic [1:0] GATE_SRC_CMP  = 2'h2;
  localparam logic [1:0] GATE_SRC_RSVD = 2'h3;

  // ----------------------------------------------------------------
  // reset values and counter landmarks
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [7:0]  T0_MAX       = 8'hFF;
  localparam logic [7:0]  T0_MIN       = 8'h00;
  localparam logic [2:0]  PRESC_RESET  = 3'h0;

  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 200;

endpackage : gtc_pkg

/* hdl/gtc_sync2.sv */
// two-flop synchroniser for level inputs arriving from outside the clock domain
`timescale 1ns/100ps

module gtc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rstSync_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } gtc_sync_t;

  gtc_sync_t st_r;
  gtc_sync_t st_nxt;

  // first stage is read only by the second stage
  always_comb begin
    st_nxt        = st_r;
    st_nxt.stage1 = asyncIn;
    st_nxt.stage2 = st_r.stage1;
  end

  // registered state
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign syncOut = st_r.stage2;

endmodule : gtc_sync2

/* hdl/gtc_timer.sv */
// gated 16-bit up-counter with asynchronous external counting and gate control
`timescale 1ns/100ps

module gtc_timer (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       timerOn,
  input  wire logic       clockSourceExt,
  input  wire logic       instrTick,
  input  wire logic       extClockPin,
  input  wire logic       asyncNoSync,
  input  wire logic [1:0] prescaleSelect,
  input  wire logic       sleepMode,
  input  wire logic       gateEnable,
  input  wire logic       gatePolarity,
  input  wire logic [1:0] gateSourceSelect,
  input  wire logic       gateToggle,
  input  wire logic       singlePulse,
  input  wire logic       goSet,
  input  wire logic       goClear,
  input  wire logic       gateInputPin,
  input  wire logic [7:0] eightBitTimer,
  input  wire logic       comparatorSyncOut,
  input  wire logic       countWriteHigh,
  input  wire logic       countWriteLow,
  input  wire logic [7:0] countWriteData,
  input  wire logic       specialEventTrigger,
  input  wire logic       overflowFlagClear,
  input  wire logic       gateEventFlagClear,
  input  wire logic       overflowIrqEn,
  input  wire logic       gateEventIrqEn,
  input  wire logic       peripheralIrqEn,
  input  wire logic       globalIrqEn,
  output logic [7:0]      countHighByte,
  output logic [7:0]      countLowByte,
  output logic            gateLevelStatus,
  output logic            pulseAcquireGo,
  output logic            gateEventFlag,
  output logic            overflowFlag,
  output logic            irqRequest,
  output logic            wakeRequest
);

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstPipe_r;
  logic       rstSync_n;
  logic [2:0] pinSync;

  // reset asserts at once, releases after two clean edges
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe_r <= 2'b00;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_r[1];

  gtc_sync2 #(
    .WIDTH (3)
  ) u_pinSync (
    .clock     (clock),
    .rstSync_n (rstSync_n),
    .asyncIn   ({comparatorSyncOut, gateInputPin, extClockPin}),
    .syncOut   (pinSync)
  );

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] prescaleLast(input logic [1:0] sel);
    prescaleLast = 3'((4'h1 << sel) - 4'h1);
  endfunction : prescaleLast

  function automatic logic gateSource(input logic [1:0] sel, input logic pin,
                                      input logic t0, input logic cmp);
    if (sel == gtc_pkg::GATE_SRC_PIN) begin
      gateSource = pin;
    end else if (sel == gtc_pkg::GATE_SRC_T0) begin
      gateSource = t0;
    end else if (sel == gtc_pkg::GATE_SRC_CMP) begin
      gateSource = cmp;
    end else begin
      gateSource = 1'b0;
    end
  endfunction : gateSource

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic [2:0]  presc;
    logic        extPrev;
    logic        extRiseAligned;
    logic [7:0]  t0Prev;
    logic        t0Pulse;
    logic        srcPrev;
    logic        toggleFf;
    logic        ctlPrev;
    logic        goBit;
    logic        spActive;
    logic        gateLvl;
    logic        gateEvt;
    logic        ovf;
    logic        irq;
    logic        wake;
  } gtc_state_t;

  gtc_state_t st_r;
  gtc_state_t st_nxt;

  // combinational terms shared with the checks
  logic srcRaw;
  logic gateCtl;
  logic ctlRise;
  logic ctlFall;
  logic gateOpen;
  logic tick;
  logic sleepRun;
  logic countEn;
  logic prescWrap;
  logic incNow;
  logic anyWrite;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // timer0 wrap becomes a one-cycle rising pulse into the gate path
    st_nxt.t0Prev  = eightBitTimer;
    st_nxt.t0Pulse = (st_r.t0Prev == gtc_pkg::T0_MAX) && (eightBitTimer == gtc_pkg::T0_MIN);

    srcRaw = gateSource(gateSourceSelect, pinSync[1], st_r.t0Pulse, pinSync[2]);
    st_nxt.srcPrev = srcRaw;

    // toggle flip-flop; held clear when toggle is off or the timer is off
    if (!gateToggle || !timerOn) begin
      st_nxt.toggleFf = 1'b0;
    end else if (srcRaw && !st_r.srcPrev) begin
      st_nxt.toggleFf = !st_r.toggleFf;
    end

    // polarity turns the (possibly toggled) source into an active-high control
    gateCtl = (gateToggle ? st_r.toggleFf : srcRaw) ~^ gatePolarity;
    st_nxt.ctlPrev = gateCtl;
    ctlRise = gateCtl && !st_r.ctlPrev;
    ctlFall = !gateCtl && st_r.ctlPrev;

    // single-pulse acquisition: arm on go, open on next rise, finish on fall
    if (!singlePulse) begin
      st_nxt.spActive = 1'b0;
    end else if (st_r.spActive && ctlFall) begin
      st_nxt.spActive = 1'b0;
    end else if (st_r.goBit && !st_r.spActive && ctlRise) begin
      st_nxt.spActive = 1'b1;
    end
    if (singlePulse && st_r.spActive && ctlFall) begin
      st_nxt.goBit = 1'b0;
    end else if (goSet) begin
      st_nxt.goBit = 1'b1;
    end else if (goClear) begin
      st_nxt.goBit = 1'b0;
    end

    gateOpen = singlePulse ? (st_r.spActive && gateCtl) : gateCtl;
    st_nxt.gateLvl = gateOpen;

    // gate event flag: a fresh falling level wins over a clear
    if (st_r.gateLvl && !gateOpen) begin
      st_nxt.gateEvt = 1'b1;
    end else if (gateEventFlagClear) begin
      st_nxt.gateEvt = 1'b0;
    end

    // incrementing edge; sync mode takes one more alignment stage, so
    // switching modes can lose or repeat one edge
    st_nxt.extPrev        = pinSync[0];
    st_nxt.extRiseAligned = pinSync[0] && !st_r.extPrev;
    if (clockSourceExt) begin
      tick = asyncNoSync ? (pinSync[0] && !st_r.extPrev) : st_r.extRiseAligned;
    end else begin
      tick = instrTick;
    end

    // sleep halts the count except in async external counting; gate, flags and interrupts keep running
    sleepRun = !sleepMode || (asyncNoSync && clockSourceExt);
    countEn  = timerOn && (!gateEnable || gateOpen) && sleepRun;

    prescWrap = (st_r.presc == prescaleLast(prescaleSelect));
    incNow    = 1'b0;
    if (tick && countEn) begin
      st_nxt.presc = prescWrap ? gtc_pkg::PRESC_RESET : 3'(st_r.presc + 3'h1);
      incNow       = prescWrap;
    end

    anyWrite = countWriteHigh || countWriteLow;
    if (anyWrite) begin
      // byte write beats the compare clear and resets the hidden prescaler
      st_nxt.presc = gtc_pkg::PRESC_RESET;
      if (countWriteHigh) begin
        st_nxt.count[15:8] = countWriteData;
      end
      if (countWriteLow) begin
        st_nxt.count[7:0] = countWriteData;
      end
    end else if (specialEventTrigger) begin
      st_nxt.count = gtc_pkg::COUNT_RESET;
    end else if (incNow) begin
      st_nxt.count = 16'(st_r.count + 16'h0001);
    end

    // overflow only from a real rollover, never from the compare clear
    if (incNow && !anyWrite && !specialEventTrigger && st_r.count == gtc_pkg::COUNT_MAX) begin
      st_nxt.ovf = 1'b1;
    end else if (overflowFlagClear) begin
      st_nxt.ovf = 1'b0;
    end

    // wake needs no global enable; servicing does
    st_nxt.wake = st_r.ovf && overflowIrqEn && timerOn && peripheralIrqEn;
    st_nxt.irq  = peripheralIrqEn && globalIrqEn &&
                  ((st_r.ovf && overflowIrqEn && timerOn) ||
                   (st_r.gateEvt && gateEventIrqEn));
  end

  // registered state
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  // byte reads come from the settled register, never mid-increment
  assign countHighByte   = st_r.count[15:8];
  assign countLowByte    = st_r.count[7:0];
  assign gateLevelStatus = st_r.gateLvl;
  assign pulseAcquireGo  = st_r.goBit;
  assign gateEventFlag   = st_r.gateEvt;
  assign overflowFlag    = st_r.ovf;
  assign irqRequest      = st_r.irq;
  assign wakeRequest     = st_r.wake;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstSync_n);

  sequence quietBus;
    !countWriteHigh && !countWriteLow && !specialEventTrigger;
  endsequence

  sequence pulseDone;
    singlePulse && st_r.spActive && ctlFall;
  endsequence

  wrap_sets_flag_a: assert property (
    quietBus and (incNow && st_r.count == gtc_pkg::COUNT_MAX)
    |=> st_r.count == gtc_pkg::COUNT_RESET && st_r.ovf)
    else $error("rollover did not clear count and set overflow");

  event_clear_a: assert property (
    (specialEventTrigger && !countWriteHigh && !countWriteLow && !st_r.ovf && !incNow)
    |=> st_r.count == gtc_pkg::COUNT_RESET && !st_r.ovf)
    else $error("special event did not clear count cleanly");

  write_wins_a: assert property (
    (countWriteLow && specialEventTrigger)
    |=> st_r.count[7:0] == $past(countWriteData))
    else $error("special event overrode a byte write");

  hold_gate_a: assert property (
    quietBus and (timerOn && gateEnable && !gateOpen)
    |=> $stable(st_r.count))
    else $error("count moved while the gate was closed");

  toggle_held_a: assert property (
    (!gateToggle || !timerOn) [*2] |-> !st_r.toggleFf)
    else $error("toggle flip-flop not held clear");

  go_done_a: assert property (
    pulseDone |=> !st_r.goBit && !st_r.spActive ##1 !st_r.spActive)
    else $error("go bit not cleared at trailing edge");

  gate_flag_a: assert property (
    $fell(st_r.gateLvl) |-> st_r.gateEvt)
    else $error("gate falling level did not set event flag");

  sleep_hold_a: assert property (
    quietBus and (sleepMode && !(asyncNoSync && clockSourceExt))
    |=> $stable(st_r.count))
    else $error("count moved in sleep outside async external mode");

  presc_clear_a: assert property (
    (countWriteHigh || countWriteLow) |=> st_r.presc == gtc_pkg::PRESC_RESET)
    else $error("byte write did not clear prescaler");

  irq_enables_a: assert property (
    irqRequest |-> $past(globalIrqEn) && $past(peripheralIrqEn))
    else $error("interrupt raised without global and peripheral enables");

  // watches the raw timer0 value, so a broken wrap compare in the pulse logic is caught
  t0_pulse_a: assert property (
    ($past(rstSync_n) && $past(eightBitTimer) == gtc_pkg::T0_MAX && eightBitTimer == gtc_pkg::T0_MIN)
    |=> st_r.t0Pulse)
    else $error("timer0 wrap did not raise a gate pulse");

endmodule : gtc_timer

/* verification/gtc_partner_model.sv */
// model of the pins and on-chip sources that feed the gated timer
`timescale 1ns/100ps

module gtc_partner_model (
  input  wire logic       clock,
  input  wire logic       extRun,
  input  wire logic       t0Run,
  input  wire logic       gateLvl,
  input  wire logic       cmpLvl,
  output logic            extClockPin,
  output logic            gateInputPin,
  output logic            comparatorSyncOut,
  output logic [7:0]      eightBitTimer
);
  // ----------------------------------------------------------------
  // source behaviour
  // ----------------------------------------------------------------
  logic [1:0] phase;

  // every source starts at a defined level so the first sync stage sees no unknown
  initial begin
    phase = 2'h0;
    extClockPin = 1'b0;
    gateInputPin = 1'b0;
    comparatorSyncOut = 1'b0;
    eightBitTimer = 8'h00;
  end

  // external clock toggles every four cycles and parks low outside a burst,
  // so every burst ends on a falling edge and no rise is half counted
  always @(posedge clock) begin
    if (t0Run) begin
      eightBitTimer <= eightBitTimer + 8'h01;
    end
    if (extRun) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        extClockPin <= ~extClockPin;
      end
    end else begin
      phase <= 2'h0;
      extClockPin <= 1'b0;
    end
    gateInputPin <= gateLvl;
    comparatorSyncOut <= cmpLvl;
  end
endmodule : gtc_partner_model

/* verification/tb.sv */
// self-checking bench for the gated timer
`timescale 1ns/100ps

module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock, reset_n, timerOn, clockSourceExt, instrTick, asyncNoSync, sleepMode;
  logic gateEnable, gatePolarity, gateToggle, singlePulse, goSet, goClear;
  logic countWriteHigh, countWriteLow, specialEventTrigger, overflowFlagClear, gateEventFlagClear;
  logic overflowIrqEn, gateEventIrqEn, peripheralIrqEn, globalIrqEn;
  logic [1:0] prescaleSelect, gateSourceSelect;
  logic [7:0] countWriteData, countHighByte, countLowByte, eightBitTimer;
  logic extClockPin, gateInputPin, comparatorSyncOut, gateLevelStatus, pulseAcquireGo;
  logic gateEventFlag, overflowFlag, irqRequest, wakeRequest;
  logic extRun, t0Run, gateLvl, cmpLvl;
  logic [15:0] cnt, c0;
  int failures, checkCount, i;

  assign cnt = {countHighByte, countLowByte};

  gtc_timer dut (.clock, .reset_n, .timerOn, .clockSourceExt, .instrTick, .extClockPin, .asyncNoSync,
    .prescaleSelect, .sleepMode, .gateEnable, .gatePolarity, .gateSourceSelect, .gateToggle, .singlePulse,
    .goSet, .goClear, .gateInputPin, .eightBitTimer, .comparatorSyncOut, .countWriteHigh, .countWriteLow,
    .countWriteData, .specialEventTrigger, .overflowFlagClear, .gateEventFlagClear, .overflowIrqEn,
    .gateEventIrqEn, .peripheralIrqEn, .globalIrqEn, .countHighByte, .countLowByte, .gateLevelStatus,
    .pulseAcquireGo, .gateEventFlag, .overflowFlag, .irqRequest, .wakeRequest);

  gtc_partner_model partner (.clock, .extRun, .t0Run, .gateLvl, .cmpLvl, .extClockPin, .gateInputPin,
    .comparatorSyncOut, .eightBitTimer);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (failures == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  // one-cycle strobe, launched and dropped on falling edges
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse

  // extra idle cycle lets the last increment settle before a read
  task automatic tick(input int n);
    instrTick = 1'b1;
    cyc(n);
    instrTick = 1'b0;
    cyc(1);
  endtask : tick

  // both bytes share one data bus, so the pair takes two strobes
  task automatic wr(input logic [15:0] v);
    countWriteData = v[15:8];
    pulse(countWriteHigh);
    countWriteData = v[7:0];
    pulse(countWriteLow);
  endtask : wr

  // pin level plus room for the two-flop sync and the status register
  task automatic gate(input logic l);
    gateLvl = l;
    cyc(6);
  endtask : gate

  task automatic burst(input int n);
    extRun = 1'b1;
    cyc(n);
    extRun = 1'b0;
    cyc(8);
  endtask : burst

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_overflow();
    timerOn = 1'b0;
    wr(16'hFFFF);
    timerOn = 1'b1;
    tick(1);
    chk("rollover", cnt, 16'h0000);
    chk("overflow flag", overflowFlag, 1'b1);
    chk("irq without global", irqRequest, 1'b0);
    chk("wake", wakeRequest, 1'b1);
    globalIrqEn = 1'b1;
    cyc(2);
    chk("irq", irqRequest, 1'b1);
    overflowIrqEn = 1'b0;
    cyc(2);
    chk("irq needs ovf enable", irqRequest, 1'b0);
    overflowIrqEn = 1'b1;
    globalIrqEn = 1'b0;
    pulse(overflowFlagClear);
  endtask : s_overflow

  task automatic s_event();
    wr(16'h1200);
    tick(1);
    pulse(specialEventTrigger);
    cyc(1);
    chk("event clear", cnt, 16'h0000);
    chk("event no flag", overflowFlag, 1'b0);
    wr(16'h1200);
    tick(1);
    countWriteData = 8'hA5;
    countWriteLow = 1'b1;
    specialEventTrigger = 1'b1;
    cyc(1);
    countWriteLow = 1'b0;
    specialEventTrigger = 1'b0;
    cyc(1);
    chk("write wins", cnt, 16'h12A5);
    prescaleSelect = 2'h1;
    tick(1);
    wr(16'h0000);
    tick(1);
    chk("prescale cleared", cnt, 16'h0000);
    tick(1);
    chk("prescale wrap", cnt, 16'h0001);
    prescaleSelect = 2'h3;
    wr(16'h0000);
    tick(7);
    chk("prescale 8 hold", cnt, 16'h0000);
    tick(1);
    chk("prescale 8 wrap", cnt, 16'h0001);
    prescaleSelect = 2'h0;
  endtask : s_event

  task automatic s_gate();
    gateEnable = 1'b1;
    gatePolarity = 1'b1;
    c0 = cnt;
    tick(4);
    chk("gate shut", cnt, c0);
    // the polarity change above already dropped the level, so start the event check clean
    pulse(gateEventFlagClear);
    gate(1'b1);
    chk("gate level", gateLevelStatus, 1'b1);
    tick(4);
    chk("gate open high", cnt, c0 + 16'h4);
    gate(1'b0);
    chk("gate event", gateEventFlag, 1'b1);
    gatePolarity = 1'b0;
    cyc(4);
    tick(4);
    chk("gate open low", cnt, c0 + 16'h8);
    gatePolarity = 1'b1;
    gateEnable = 1'b0;
    cyc(4);
    pulse(gateEventFlagClear);
    gate(1'b1);
    chk("level ungated", gateLevelStatus, 1'b1);
    gate(1'b0);
    chk("event ungated", gateEventFlag, 1'b1);
    gateEventIrqEn = 1'b1;
    globalIrqEn = 1'b1;
    cyc(2);
    chk("gate irq", irqRequest, 1'b1);
    pulse(gateEventFlagClear);
    cyc(2);
    chk("gate irq cleared", irqRequest, 1'b0);
    gateEventIrqEn = 1'b0;
    globalIrqEn = 1'b0;
  endtask : s_gate

  task automatic s_source();
    cmpLvl = 1'b1;
    gateSourceSelect = 2'h2;
    cyc(6);
    chk("comparator source", gateLevelStatus, 1'b1);
    gateSourceSelect = 2'h3;
    cyc(6);
    chk("reserved source", gateLevelStatus, 1'b0);
    pulse(gateEventFlagClear);
    gateSourceSelect = 2'h1;
    t0Run = 1'b1;
    for (i = 0; i < 300 && gateEventFlag !== 1'b1; i++) cyc(1);
    chk("timer0 wrap pulse", gateEventFlag, 1'b1);
    if (gateEventFlag !== 1'b1) end_sim();
    t0Run = 1'b0;
    cmpLvl = 1'b0;
    gateSourceSelect = 2'h0;
    cyc(4);
    pulse(gateEventFlagClear);
  endtask : s_source

  task automatic s_toggle();
    gateToggle = 1'b1;
    gate(1'b1);
    gate(1'b0);
    chk("toggle holds", gateLevelStatus, 1'b1);
    gateToggle = 1'b0;
    cyc(3);
    chk("toggle cleared", gateLevelStatus, 1'b0);
    gateToggle = 1'b1;
    gate(1'b1);
    gate(1'b0);
    timerOn = 1'b0;
    c0 = cnt;
    tick(3);
    chk("off clears flop", gateLevelStatus, 1'b0);
    chk("off holds count", cnt, c0);
    timerOn = 1'b1;
    gateToggle = 1'b0;
    cyc(4);
    pulse(gateEventFlagClear);
  endtask : s_toggle

  task automatic s_single();
    gateEnable = 1'b1;
    singlePulse = 1'b1;
    pulse(goSet);
    chk("go armed", pulseAcquireGo, 1'b1);
    c0 = cnt;
    tick(3);
    chk("waits for edge", cnt, c0);
    gate(1'b1);
    tick(3);
    gate(1'b0);
    chk("go done", pulseAcquireGo, 1'b0);
    chk("pulse counted", cnt, c0 + 16'h3);
    gate(1'b1);
    tick(3);
    gate(1'b0);
    chk("later pulse ignored", cnt, c0 + 16'h3);
    gateToggle = 1'b1;
    pulse(goSet);
    gate(1'b1);
    gate(1'b0);
    tick(2);
    gate(1'b1);
    gate(1'b0);
    tick(2);
    chk("full cycle", cnt, c0 + 16'h5);
    chk("go done toggled", pulseAcquireGo, 1'b0);
    pulse(goSet);
    chk("go rearmed", pulseAcquireGo, 1'b1);
    singlePulse = 1'b0;
    pulse(goClear);
    chk("go cleared", pulseAcquireGo, 1'b0);
    gateToggle = 1'b0;
    gateEnable = 1'b0;
  endtask : s_single

  // sleep counting: only the unsynchronised external path may advance
  task automatic s_async();
    clockSourceExt = 1'b1;
    asyncNoSync = 1'b1;
    sleepMode = 1'b1;
    c0 = cnt;
    burst(40);
    chk("async in sleep", cnt, c0 + 16'h5);
    asyncNoSync = 1'b0;
    burst(40);
    chk("sync in sleep", cnt, c0 + 16'h5);
    sleepMode = 1'b0;
    burst(40);
    chk("sync awake", cnt, c0 + 16'hA);
    timerOn = 1'b0;
    wr(16'hFFFF);
    timerOn = 1'b1;
    asyncNoSync = 1'b1;
    sleepMode = 1'b1;
    burst(8);
    chk("sleep wrap", cnt, 16'h0000);
    chk("sleep wake", wakeRequest, 1'b1);
    chk("no service", irqRequest, 1'b0);
  endtask : s_async

  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    {reset_n, timerOn, clockSourceExt, instrTick, asyncNoSync, sleepMode, gateEnable} = '0;
    {gatePolarity, gateToggle, singlePulse, goSet, goClear, countWriteHigh, countWriteLow} = '0;
    {specialEventTrigger, overflowFlagClear, gateEventFlagClear, gateEventIrqEn, globalIrqEn} = '0;
    {prescaleSelect, gateSourceSelect, countWriteData, extRun, t0Run, gateLvl, cmpLvl} = '0;
    overflowIrqEn = 1'b1;
    peripheralIrqEn = 1'b1;
    failures = 0;
    checkCount = 0;
    cyc(3);
    reset_n = 1'b1;
    cyc(3);
    timerOn = 1'b1;
    tick(5);
    chk("free count", cnt, 16'h0005);
    s_overflow();
    s_event();
    s_gate();
    s_source();
    s_toggle();
    s_single();
    s_async();
    end_sim();
  end
endmodule : tb
